// File: smo_btn.v
// Button press, auto-repeat and long-hold detection.
// Assumes a clean synchronous level and a 1 ms tick pulse.
`include "smo_defs.vh"

module smo_btn (
   input wire sys_clk,
   input wire rst_n,
   input wire tick,
   input wire pressed,
   output reg step,
   output reg long_hold
);
   reg pressed_q;
   reg [11:0] held_ms;
   reg [7:0] rep_ms;
   wire [7:0] period;

   // Repeat speeds up after the longer hold
   assign period = (held_ms >= `SMO_FAST_HOLD_MS) ? `SMO_FAST_PERIOD_MS
                                                   : `SMO_SLOW_PERIOD_MS;

   // Press edge, hold timing and repeat pulses
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pressed_q <= 1'b0;
         held_ms <= 12'h000;
         rep_ms <= 8'h00;
         step <= 1'b0;
         long_hold <= 1'b0;
      end
      else
      begin
         pressed_q <= pressed;
         step <= 1'b0;
         long_hold <= pressed && (held_ms >= `SMO_OPEN_HOLD_MS);
         if (!pressed)
         begin
            held_ms <= 12'h000;
            rep_ms <= 8'h00;
         end
         else if (!pressed_q)
            step <= 1'b1;
         else if (tick)
         begin
            if (held_ms < `SMO_FAST_HOLD_MS)
               held_ms <= held_ms + 12'h001;
            if (held_ms >= `SMO_REPEAT_HOLD_MS)
            begin
               if (rep_ms >= period - 8'h01)
               begin
                  step <= 1'b1;
                  rep_ms <= 8'h00;
               end
               else
                  rep_ms <= rep_ms + 8'h01;
            end
         end
      end
   end
endmodule // smo_btn

// File: smo_defs.vh
// Constants for the setpoint menu and output decision block.
// Assumes a 125 MHz system clock and a 1 ms tick timebase.
`ifndef SMO_DEFS_VH
`define SMO_DEFS_VH

// Switching function codes
`define SMO_MODE_NONE 3'h0
`define SMO_MODE_TWO 3'h1
`define SMO_MODE_THREE 3'h2
`define SMO_MODE_TWO_AL 3'h3
`define SMO_MODE_THREE_AL 3'h4
`define SMO_MODE_AL 3'h5

// Parameter indices
`define SMO_P_ON1 3'h0
`define SMO_P_OFF1 3'h1
`define SMO_P_ON2 3'h2
`define SMO_P_OFF2 3'h3
`define SMO_P_HI 3'h4
`define SMO_P_LO 3'h5
`define SMO_P_WAIT 3'h6
`define SMO_P_END 3'h7

// Timebase
`define SMO_CLK_MHZ 125
`define SMO_TICK_US 1000
`define SMO_MENU_TIMEOUT_MS 17'h0EA60
`define SMO_OPEN_HOLD_MS 12'h7D0
`define SMO_REPEAT_HOLD_MS 12'h3E8
`define SMO_FAST_HOLD_MS 12'hBB8
`define SMO_SLOW_PERIOD_MS 8'hC8
`define SMO_FAST_PERIOD_MS 8'h32
`define SMO_MS_PER_SEC 10'h3E8
`define SMO_SW_UNIT_MS 12'h00A

// Value limits and reset values
`define SMO_VAL_MAX 16'h270F
`define SMO_VAL_MIN 16'hF831
`define SMO_WAIT_MIN 16'h0000
`define SMO_RST_POINT 16'h0000

`endif

// File: smo_menu.v
// Setpoint menu, limit alarms and output mapping.
// Assumes synchronous button levels (high while pressed) and a
// measured value already scaled to display digits.
`include "smo_defs.vh"

module smo_menu #(
   parameter TICK_CYCLES = `SMO_TICK_US * `SMO_CLK_MHZ
) (
   input wire sys_clk,
   input wire rst_n,
   input wire btn_select,
   input wire btn_up,
   input wire btn_down,
   input wire signed [15:0] measured_value,
   input wire value_error,
   input wire [2:0] switching_function_select,
   input wire [7:0] out1_switch_wait,
   input wire [7:0] out2_switch_wait,
   input wire out1_fault_state,
   input wire out2_fault_state,
   output reg menu_active,
   output reg menu_editing,
   output reg [2:0] menu_param,
   output reg [15:0] menu_value,
   output reg alarm_max,
   output reg alarm_min,
   output reg relay1,
   output reg relay2,
   output reg out3
);
   localparam ST_IDLE = 2'h0;
   localparam ST_NAME = 2'h1;
   localparam ST_EDIT = 2'h2;
   localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
   localparam [16:0] TICK_LAST = TICK_FULL[16:0];

   ////////////////////////////////////////////////////////////////
   // Functions

   // Next parameter of the mode sequence; END gives the first
   function [2:0] param_next;
      input [2:0] mode;
      input [2:0] cur;
      begin
         param_next = `SMO_P_END;
         case (mode)
            `SMO_MODE_TWO, `SMO_MODE_TWO_AL:
            begin
               if (cur == `SMO_P_END)
                  param_next = `SMO_P_ON1;
               else if (cur == `SMO_P_ON1)
                  param_next = `SMO_P_OFF1;
               else if (cur == `SMO_P_OFF1 && mode == `SMO_MODE_TWO_AL)
                  param_next = `SMO_P_HI;
               else if (cur == `SMO_P_HI || cur == `SMO_P_LO)
                  param_next = cur + 3'h1;
            end
            `SMO_MODE_THREE, `SMO_MODE_THREE_AL:
            begin
               if (cur == `SMO_P_END)
                  param_next = `SMO_P_ON1;
               else if (cur < `SMO_P_OFF2)
                  param_next = cur + 3'h1;
               else if (cur < `SMO_P_WAIT && mode == `SMO_MODE_THREE_AL)
                  param_next = cur + 3'h1;
            end
            `SMO_MODE_AL:
            begin
               if (cur == `SMO_P_END)
                  param_next = `SMO_P_HI;
               else if (cur == `SMO_P_HI || cur == `SMO_P_LO)
                  param_next = cur + 3'h1;
            end
            default:
               param_next = `SMO_P_END;
         endcase
      end
   endfunction

   // One step up or down with wrap-around
   function [15:0] adjust;
      input [15:0] v;
      input up;
      input [2:0] idx;
      reg [15:0] lo;
      begin
         lo = (idx == `SMO_P_WAIT) ? `SMO_WAIT_MIN : `SMO_VAL_MIN;
         if (up)
            adjust = ($signed(v) >= $signed(`SMO_VAL_MAX)) ? lo
                                                       : v + 16'h0001;
         else
            adjust = ($signed(v) <= $signed(lo)) ? `SMO_VAL_MAX
                                             : v - 16'h0001;
      end
   endfunction

   // Reset value of each setpoint
   function [15:0] sp_reset;
      input [2:0] idx;
      begin
         if (idx == `SMO_P_HI)
            sp_reset = `SMO_VAL_MAX;
         else if (idx == `SMO_P_LO)
            sp_reset = `SMO_VAL_MIN;
         else
            sp_reset = `SMO_RST_POINT;
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Declarations

   reg [16:0] tick_cnt;
   reg tick;
   reg [1:0] state;
   reg [16:0] idle_ms;
   reg [15:0] sp [0:6];
   integer i;
   wire sel_step;
   wire sel_long;
   wire up_step;
   wire down_step;
   wire any_step;
   wire timeout;
   wire [2:0] first_param;
   wire [2:0] following_param;
   wire [1:0] cond;
   wire [1:0] alarm;
   wire [13:0] wait_sec;
   wire func1;
   wire func2;
   wire any_alarm;

   ////////////////////////////////////////////////////////////////
   // Timebase

   // Single millisecond tick for every timed function
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         tick_cnt <= 17'h00000;
         tick <= 1'b0;
      end
      else
      begin
         tick <= (tick_cnt == TICK_LAST);
         if (tick_cnt == TICK_LAST)
            tick_cnt <= 17'h00000;
         else
            tick_cnt <= tick_cnt + 17'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Buttons

   smo_btn u_sel (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .pressed(btn_select),
      .step(sel_step),
      .long_hold(sel_long)
   );

   smo_btn u_up (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .pressed(btn_up),
      .step(up_step),
      .long_hold()
   );

   smo_btn u_down (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .pressed(btn_down),
      .step(down_step),
      .long_hold()
   );

   ////////////////////////////////////////////////////////////////
   // Menu

   assign any_step = sel_step | up_step | down_step;
   assign timeout = (idle_ms > `SMO_MENU_TIMEOUT_MS);
   assign first_param = param_next(switching_function_select, `SMO_P_END);
   assign following_param = param_next(switching_function_select, menu_param);

   // Inactivity timer, held clear while a button is down
   always @(posedge sys_clk)
   begin
      if (!rst_n)
         idle_ms <= 17'h00000;
      else if (any_step || btn_select || btn_up || btn_down || state == ST_IDLE)
         idle_ms <= 17'h00000;
      else if (tick && !timeout)
         idle_ms <= idle_ms + 17'h00001;
   end

   // Menu walk; value on display is the shadow copy
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         menu_param <= `SMO_P_END;
         menu_value <= 16'h0000;
         for (i = 0; i < 7; i = i + 1)
            sp[i] <= sp_reset(i[2:0]);
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (sel_long && first_param != `SMO_P_END)
               begin
                  state <= ST_NAME;
                  menu_param <= first_param;
                  menu_value <= sp[first_param];
               end
            end
            ST_NAME:
            begin
               if (timeout)
               begin
                  state <= ST_IDLE;
                  menu_param <= `SMO_P_END;
               end
               else if (sel_step)
               begin
                  if (following_param == `SMO_P_END)
                     state <= ST_IDLE;
                  else
                     menu_value <= sp[following_param];
                  menu_param <= following_param;
               end
               else if (up_step || down_step)
               begin
                  state <= ST_EDIT;
                  menu_value <= adjust(menu_value, up_step, menu_param);
               end
            end
            ST_EDIT:
            begin
               if (timeout)
               begin
                  state <= ST_IDLE;
                  menu_param <= `SMO_P_END;
               end
               else if (sel_step)
               begin
                  sp[menu_param] <= menu_value;
                  state <= ST_NAME;
               end
               else if (up_step || down_step)
                  menu_value <= adjust(menu_value, up_step, menu_param);
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Display status
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         menu_active <= 1'b0;
         menu_editing <= 1'b0;
      end
      else
      begin
         menu_active <= (state != ST_IDLE);
         menu_editing <= (state == ST_EDIT);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Switching functions

   smo_sw u_func1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .measured_value(measured_value),
      .engage_point(sp[`SMO_P_ON1]),
      .release_point(sp[`SMO_P_OFF1]),
      .switch_wait(out1_switch_wait),
      .value_error(value_error),
      .fault_state(out1_fault_state),
      .switch_out(func1)
   );

   smo_sw u_func2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .measured_value(measured_value),
      .engage_point(sp[`SMO_P_ON2]),
      .release_point(sp[`SMO_P_OFF2]),
      .switch_wait(out2_switch_wait),
      .value_error(value_error),
      .fault_state(out2_fault_state),
      .switch_out(func2)
   );

   ////////////////////////////////////////////////////////////////
   // Limit alarms: index 0 maximum, index 1 minimum

   assign cond[0] = measured_value > $signed(sp[`SMO_P_HI]);
   assign cond[1] = measured_value < $signed(sp[`SMO_P_LO]);
   assign wait_sec = sp[`SMO_P_WAIT][13:0];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_alarm
         reg [9:0] ms;
         reg [13:0] sec;
         // Persistence timer restarts when the condition drops
         always @(posedge sys_clk)
         begin
            if (!rst_n || !cond[g])
            begin
               ms <= 10'h000;
               sec <= 14'h0000;
            end
            else if (tick && sec < wait_sec)
            begin
               if (ms == `SMO_MS_PER_SEC - 10'h001)
               begin
                  ms <= 10'h000;
                  sec <= sec + 14'h0001;
               end
               else
                  ms <= ms + 10'h001;
            end
         end
         assign alarm[g] = cond[g] && (sec >= wait_sec);
      end
   endgenerate

   assign any_alarm = alarm[0] | alarm[1];

   ////////////////////////////////////////////////////////////////
   // Output mapping

   // Relay and alarm outputs per switching function
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         relay1 <= 1'b0;
         relay2 <= 1'b0;
         out3 <= 1'b0;
         alarm_max <= 1'b0;
         alarm_min <= 1'b0;
      end
      else
      begin
         alarm_max <= alarm[0];
         alarm_min <= alarm[1];
         case (switching_function_select)
            `SMO_MODE_TWO:
            begin
               relay1 <= func1;
               relay2 <= ~func1;
               out3 <= func1;
            end
            `SMO_MODE_THREE:
            begin
               relay1 <= func1;
               relay2 <= func2;
               out3 <= func1;
            end
            `SMO_MODE_TWO_AL:
            begin
               relay1 <= func1;
               relay2 <= ~any_alarm;
               out3 <= ~any_alarm;
            end
            `SMO_MODE_THREE_AL:
            begin
               relay1 <= func1;
               relay2 <= func2;
               out3 <= ~any_alarm;
            end
            `SMO_MODE_AL:
            begin
               relay1 <= ~alarm[0];
               relay2 <= ~alarm[1];
               out3 <= ~any_alarm;
            end
            default:
            begin
               relay1 <= 1'b0;
               relay2 <= 1'b0;
               out3 <= 1'b0;
            end
         endcase
      end
   end
endmodule // smo_menu

// File: smo_menu_properties.sv
// Checker for menu timing, stepping and alarm outputs.
// Assumes it is bound to smo_menu and sees only its ports.
`include "smo_defs.vh"
module smo_menu_check #(
   parameter TICK_CYCLES = 125000
) (
   input wire sys_clk,
   input wire rst_n,
   input wire btn_select,
   input wire btn_up,
   input wire btn_down,
   input wire [2:0] switching_function_select,
   input wire menu_active,
   input wire menu_editing,
   input wire [2:0] menu_param,
   input wire [15:0] menu_value,
   input wire alarm_max,
   input wire alarm_min,
   input wire relay1,
   input wire out3
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [31:0] sel_cnt;
   reg [31:0] idle_cnt;
   reg [15:0] val_at;
   wire any_btn = btn_select | btn_up | btn_down;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Select hold length, idle time in menu, value before a press
   always @(posedge sys_clk)
   begin
      if (!rst_n || !btn_select)
         sel_cnt <= 32'h0;
      else
         sel_cnt <= sel_cnt + 32'h1;
      if (!rst_n || any_btn || !menu_active)
         idle_cnt <= 32'h0;
      else
         idle_cnt <= idle_cnt + 32'h1;
      if (!btn_up && !btn_down)
         val_at <= menu_value;
   end
   ////////////////////////////////////////////////////////////////
   open_hold_a: assert property ($rose(menu_active) |-> sel_cnt >= 1990 * TICK_CYCLES)
      else $error("menu opened without long select hold");
   idle_limit_a: assert property (menu_active |-> idle_cnt <= 60000 * TICK_CYCLES + 8)
      else $error("menu stayed open past idle limit");
   early_abort_a: assert property ($fell(menu_active) && idle_cnt > 100
      |-> idle_cnt >= 60000 * TICK_CYCLES - 16) else $error("menu aborted too early");
   up_step_a: assert property ($rose(btn_up) && !btn_select && menu_active
      && val_at != `SMO_VAL_MAX |-> ##[1:4] menu_value == val_at + 16'h0001)
      else $error("up press did not add one");
   up_wrap_a: assert property ($rose(btn_up) && !btn_select && menu_active
      && val_at == `SMO_VAL_MAX |-> ##[1:4] (menu_value == `SMO_VAL_MIN
      || menu_value == `SMO_WAIT_MIN)) else $error("up at max did not wrap");
   down_wrap_a: assert property ($rose(btn_down) && !btn_up && !btn_select && menu_active
      && menu_param != `SMO_P_WAIT && val_at == `SMO_VAL_MIN |-> ##[1:4]
      menu_value == `SMO_VAL_MAX) else $error("down at min did not wrap");
   edit_store_a: assert property ($fell(menu_editing) && menu_active
      |-> $past(btn_select, 2) || $past(btn_select, 3) || $past(btn_select, 4))
      else $error("edit ended without select");
   alarm_order_a: assert property ($changed(menu_param) && menu_active && $past(menu_active)
      && switching_function_select == `SMO_MODE_AL |-> menu_param == $past(menu_param) + 3'h1)
      else $error("alarm parameter order wrong");
   max_out_a: assert property ($rose(alarm_max) && switching_function_select == `SMO_MODE_AL
      |-> ##[0:2] !relay1) else $error("relay1 not inverted max alarm");
   comb_out_a: assert property ($rose(alarm_max || alarm_min)
      && switching_function_select == `SMO_MODE_AL |-> ##[0:2] !out3)
      else $error("out3 not inverted combined alarm");
endmodule // smo_menu_check

bind smo_menu smo_menu_check #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .btn_select(btn_select), .btn_up(btn_up), .btn_down(btn_down),
   .switching_function_select(switching_function_select), .menu_active(menu_active),
   .menu_editing(menu_editing), .menu_param(menu_param), .menu_value(menu_value),
   .alarm_max(alarm_max), .alarm_min(alarm_min), .relay1(relay1), .out3(out3));

// File: smo_panel.sv
// Front panel model: presses and releases the three buttons.
// Assumes one caller at a time and the panel clock of the block.
module smo_panel (
   input wire logic sys_clk,
   output logic btn_select,
   output logic btn_up,
   output logic btn_down
);
   timeunit 1ns;
   timeprecision 1ns;
   // Buttons start released
   initial
   begin
      btn_select = 1'b0;
      btn_up = 1'b0;
      btn_down = 1'b0;
   end
   // One button held for cyc cycles, then a release gap
   task automatic press(input int which, input int cyc);
      @(posedge sys_clk);
      case (which)
         0: btn_select <= 1'b1;
         1: btn_up <= 1'b1;
         default: btn_down <= 1'b1;
      endcase
      repeat (cyc) @(posedge sys_clk);
      btn_select <= 1'b0;
      btn_up <= 1'b0;
      btn_down <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // smo_panel

// File: smo_sw.v
// One hysteresis switching function with delay and fault state.
// Assumes a 1 ms tick pulse and a delay given in 10 ms units.
`include "smo_defs.vh"

module smo_sw (
   input wire sys_clk,
   input wire rst_n,
   input wire tick,
   input wire signed [15:0] measured_value,
   input wire signed [15:0] engage_point,
   input wire signed [15:0] release_point,
   input wire [7:0] switch_wait,
   input wire value_error,
   input wire fault_state,
   output reg switch_out
);
   reg decision;
   reg next_decision;
   reg [11:0] wait_ms;
   wire [11:0] wait_target;

   assign wait_target = {4'h0, switch_wait} * `SMO_SW_UNIT_MS;

   // Hysteresis decision, direction set by point order
   always @*
   begin
      next_decision = decision;
      if (engage_point < release_point)
      begin
         if (measured_value < engage_point)
            next_decision = 1'b1;
         else if (measured_value > release_point)
            next_decision = 1'b0;
      end
      else
      begin
         if (measured_value > engage_point)
            next_decision = 1'b1;
         else if (measured_value < release_point)
            next_decision = 1'b0;
      end
   end

   // Output follows decision after the wait
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         decision <= 1'b0;
         wait_ms <= 12'h000;
         switch_out <= 1'b0;
      end
      else
      begin
         decision <= next_decision;
         if (value_error)
         begin
            switch_out <= fault_state;
            wait_ms <= 12'h000;
         end
         else if (decision == switch_out)
            wait_ms <= 12'h000;
         else if (tick)
         begin
            if (wait_ms + 12'h001 >= wait_target)
            begin
               switch_out <= decision;
               wait_ms <= 12'h000;
            end
            else
               wait_ms <= wait_ms + 12'h001;
         end
      end
   end
endmodule // smo_sw

// File: test_smo_menu.sv
// Self-checking bench for the setpoint menu and output block.
// Assumes smo_panel drives the buttons and the checker is bound in.
`include "smo_defs.vh"
module test_smo_menu;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 1;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic signed [15:0] measured_value = 16'sh0000;
   logic value_error = 1'b0;
   logic [2:0] mode = `SMO_MODE_AL;
   logic [7:0] wait1 = 8'h01;
   logic f1 = 1'b0;
   wire btn_select, btn_up, btn_down, menu_active, menu_editing;
   wire alarm_max, alarm_min, relay1, relay2, out3;
   wire [2:0] menu_param;
   wire [15:0] menu_value;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc_cnt = 0;
   smo_panel u_panel (.sys_clk(sys_clk), .btn_select(btn_select), .btn_up(btn_up),
      .btn_down(btn_down));
   smo_menu #(.TICK_CYCLES(TK)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .btn_select(btn_select), .btn_up(btn_up), .btn_down(btn_down),
      .measured_value(measured_value), .value_error(value_error),
      .switching_function_select(mode), .out1_switch_wait(wait1), .out2_switch_wait(8'h01),
      .out1_fault_state(f1), .out2_fault_state(1'b0), .menu_active(menu_active),
      .menu_editing(menu_editing), .menu_param(menu_param), .menu_value(menu_value),
      .alarm_max(alarm_max), .alarm_min(alarm_min), .relay1(relay1), .relay2(relay2),
      .out3(out3));
   ////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 95000)
      begin
         error_cnt++;
         conclude();
      end
   end
   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      #1;
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic sel();
      u_panel.press(0, 4);
   endtask
   task automatic open_menu();
      u_panel.press(0, 2010 * TK);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Alarm-only outputs idle high with no alarm
   task automatic t_reset();
      chk("param", {13'h0, `SMO_P_END}, {13'h0, menu_param});
      chk("relay1", 16'h0001, {15'h0, relay1});
      chk("relay2", 16'h0001, {15'h0, relay2});
      chk("out3", 16'h0001, {15'h0, out3});
      $display("test reset done");
   endtask
   // Two-step menu: open, step, store, advance, leave
   task automatic t_open_edit();
      go(1);
      mode <= `SMO_MODE_TWO;
      open_menu();
      chk("active", 16'h0001, {15'h0, menu_active});
      chk("first", {13'h0, `SMO_P_ON1}, {13'h0, menu_param});
      repeat (3) u_panel.press(1, 4);
      chk("on1", 16'h0003, menu_value);
      chk("editing", 16'h0001, {15'h0, menu_editing});
      sel();
      chk("name", 16'h0000, {15'h0, menu_editing});
      sel();
      chk("second", {13'h0, `SMO_P_OFF1}, {13'h0, menu_param});
      u_panel.press(2, 4);
      chk("off1", 16'hFFFF, menu_value);
      sel();
      sel();
      chk("left", 16'h0000, {15'h0, menu_active});
      $display("test open_edit done");
   endtask
   // Engage 3 above release -1 with 10 ms delay and fault state
   task automatic t_switch();
      go(1);
      measured_value <= 16'sh0005;
      go(8);
      chk("delayed", 16'h0000, {15'h0, relay1});
      go(35);
      chk("on", 16'h0001, {15'h0, relay1});
      chk("inv", 16'h0000, {15'h0, relay2});
      chk("out3", 16'h0001, {15'h0, out3});
      go(1);
      measured_value <= 16'sh0000;
      go(40);
      chk("hyst", 16'h0001, {15'h0, relay1});
      go(1);
      measured_value <= 16'shFFFE;
      go(40);
      chk("off", 16'h0000, {15'h0, relay1});
      go(1);
      value_error <= 1'b1;
      f1 <= 1'b1;
      go(40);
      chk("fault", 16'h0001, {15'h0, relay1});
      go(1);
      value_error <= 1'b0;
      f1 <= 1'b0;
      $display("test switch done");
   endtask
   // Alarm menu with wraps, 2 s wait, restart on a short clear
   task automatic t_alarm();
      go(1);
      mode <= `SMO_MODE_AL;
      measured_value <= `SMO_VAL_MIN;
      open_menu();
      chk("hi", {13'h0, `SMO_P_HI}, {13'h0, menu_param});
      u_panel.press(1, 4);
      chk("wrap up", `SMO_VAL_MIN, menu_value);
      sel();
      sel();
      chk("lo", {13'h0, `SMO_P_LO}, {13'h0, menu_param});
      u_panel.press(2, 4);
      chk("wrap dn", `SMO_VAL_MAX, menu_value);
      u_panel.press(1, 4);
      sel();
      sel();
      chk("wait", {13'h0, `SMO_P_WAIT}, {13'h0, menu_param});
      repeat (2) u_panel.press(1, 4);
      chk("wait val", 16'h0002, menu_value);
      sel();
      sel();
      go(1);
      measured_value <= 16'sh0000;
      go(1500);
      measured_value <= `SMO_VAL_MIN;
      go(5);
      measured_value <= 16'sh0000;
      go(1900);
      chk("early", 16'h0000, {15'h0, alarm_max});
      go(200);
      chk("alarm", 16'h0001, {15'h0, alarm_max});
      chk("r1", 16'h0000, {15'h0, relay1});
      chk("r2", 16'h0001, {15'h0, relay2});
      chk("o3", 16'h0000, {15'h0, out3});
      go(1);
      measured_value <= 16'shF830;
      go(2100);
      chk("min", 16'h0002, {14'h0, alarm_min, relay2});
      go(1);
      measured_value <= `SMO_VAL_MIN;
      $display("test alarm done");
   endtask
   // Three-step alarm walk, then mapping of the other modes
   task automatic t_modes();
      go(1);
      mode <= `SMO_MODE_THREE_AL;
      open_menu();
      for (int p = 0; p < 7; p++)
      begin
         chk("walk", 16'(p), {13'h0, menu_param});
         sel();
      end
      chk("walk end", 16'h0000, {15'h0, menu_active});
      chk("three al", 16'h0001, {14'h0, relay2, out3});
      go(1);
      mode <= `SMO_MODE_TWO_AL;
      go(3);
      chk("two al", 16'h0003, {14'h0, relay2, out3});
      go(1);
      mode <= `SMO_MODE_THREE;
      go(3);
      chk("three", 16'h0000, {14'h0, relay2, out3});
      go(1);
      mode <= `SMO_MODE_NONE;
      open_menu();
      chk("none", 16'h0000, {12'h0, menu_active, relay1, relay2, out3});
      $display("test modes done");
   endtask
   // Auto-repeat, then idle abort that keeps the stored point
   task automatic t_timeout();
      go(1);
      mode <= `SMO_MODE_TWO;
      open_menu();
      chk("stored", 16'h0003, menu_value);
      u_panel.press(1, 1500 * TK);
      chk("repeat", 16'h0001, 16'(menu_value > 16'h0005 && menu_value < 16'h0009));
      go(60100 * TK);
      chk("abort", 16'h0000, {15'h0, menu_active});
      open_menu();
      chk("kept", 16'h0003, menu_value);
      sel();
      sel();
      chk("closed", 16'h0000, {15'h0, menu_active});
      $display("test timeout done");
   endtask
   // Reset then run the scenarios
   initial
   begin
      go(6);
      rst_n <= 1'b1;
      go(3);
      t_reset();
      t_open_edit();
      t_switch();
      t_alarm();
      t_modes();
      t_timeout();
      conclude();
   end
endmodule // test_smo_menu
